// File: bench/alu_checker_properties.sv
// Handshake checks on the register bus of the datapath.
`timescale 1ns/1ns
`default_nettype none
module alu_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axil_awvalid,
  input wire logic        s_axil_awready,
  input wire logic        s_axil_wvalid,
  input wire logic        s_axil_wready,
  input wire logic        s_axil_bvalid,
  input wire logic        s_axil_bready,
  input wire logic        s_axil_arvalid,
  input wire logic        s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic        s_axil_rvalid,
  input wire logic        s_axil_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  property p_aw_pulse; s_axil_awready |=> !s_axil_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready too long");
  property p_w_pulse; s_axil_wready |=> !s_axil_wready; endproperty
  a_w_pulse: assert property (p_w_pulse) else $error("wready too long");
  property p_ar_rise; $rose(s_axil_arvalid) |=> s_axil_arready; endproperty
  a_ar_rise: assert property (p_ar_rise) else $error("arready late");
  property p_ar_cause; s_axil_arready |-> $past(s_axil_arvalid); endproperty
  a_ar_cause: assert property (p_ar_cause) else $error("arready without request");
  property p_r_after_ar; s_axil_arvalid && s_axil_arready |=> s_axil_rvalid; endproperty
  a_r_after_ar: assert property (p_r_after_ar) else $error("rvalid late");
  property p_r_hold;
    s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_hold; s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_after_wr; s_wr_taken |-> ##[1:2] s_axil_bvalid; endproperty
  a_b_after_wr: assert property (p_b_after_wr) else $error("bvalid late");
endmodule
bind sat_sub_reverse_rotate_alu alu_checker alu_checker_i (.*);
`default_nettype wire

// File: bench/axil_master.sv
// Register bus master standing in for the software side.
`timescale 1ns/1ns
`default_nettype none
module axil_master (
  input  wire logic        aclk,
  output var  logic [7:0]  s_axil_awaddr,
  output var  logic        s_axil_awvalid,
  input  wire logic        s_axil_awready,
  output var  logic [31:0] s_axil_wdata,
  output var  logic [3:0]  s_axil_wstrb,
  output var  logic        s_axil_wvalid,
  input  wire logic        s_axil_wready,
  input  wire logic [1:0]  s_axil_bresp,
  input  wire logic        s_axil_bvalid,
  output var  logic        s_axil_bready,
  output var  logic [7:0]  s_axil_araddr,
  output var  logic        s_axil_arvalid,
  input  wire logic        s_axil_arready,
  input  wire logic [31:0] s_axil_rdata,
  input  wire logic [1:0]  s_axil_rresp,
  input  wire logic        s_axil_rvalid,
  output var  logic        s_axil_rready
);
  int lag = 1;
  initial begin
    s_axil_awaddr = 8'h00;
    s_axil_awvalid = 1'b0;
    s_axil_wdata = 32'h0;
    s_axil_wstrb = 4'hf;
    s_axil_wvalid = 1'b0;
    s_axil_bready = 1'b0;
    s_axil_araddr = 8'h00;
    s_axil_arvalid = 1'b0;
    s_axil_rready = 1'b0;
  end
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axil_awaddr <= a;
    s_axil_awvalid <= 1'b1;
    s_axil_wdata <= d;
    s_axil_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axil_awready && !aw) begin
        aw = 1'b1;
        s_axil_awvalid <= 1'b0;
        s_axil_awaddr <= ~a;
      end
      if (s_axil_wready && !w) begin
        w = 1'b1;
        s_axil_wvalid <= 1'b0;
        s_axil_wdata <= ~d;
      end
    end
    repeat (lag) @(posedge aclk);
    s_axil_bready <= 1'b1;
    do @(posedge aclk); while (!s_axil_bvalid);
    r = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axil_arready);
    s_axil_arvalid <= 1'b0;
    s_axil_araddr <= ~a;
    repeat (lag) @(posedge aclk);
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (!s_axil_rvalid);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench running each operation through the register bus.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import alu_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axil_awaddr;
  logic        s_axil_awvalid;
  logic        s_axil_awready;
  logic [31:0] s_axil_wdata;
  logic [3:0]  s_axil_wstrb;
  logic        s_axil_wvalid;
  logic        s_axil_wready;
  logic [1:0]  s_axil_bresp;
  logic        s_axil_bvalid;
  logic        s_axil_bready;
  logic [7:0]  s_axil_araddr;
  logic        s_axil_arvalid;
  logic        s_axil_arready;
  logic [31:0] s_axil_rdata;
  logic [1:0]  s_axil_rresp;
  logic        s_axil_rvalid;
  logic        s_axil_rready;
  logic [31:0] res;
  logic [31:0] fl;
  logic [31:0] st;
  logic [1:0]  rsp;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;
  sat_sub_reverse_rotate_alu sat_sub_reverse_rotate_alu_i (.*);
  axil_master axil_master_i (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("failures=%0d checks_done=%0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] mk(input logic [3:0] op, input logic [3:0] d, input logic [3:0] m,
                                     input logic [3:0] m2, input logic [4:0] amt, input logic sf, input logic cp);
    mk = {3'h0, shift_type_ror, cp, sf, amt, 4'h2, m2, m, d, op};
  endfunction
  task automatic run(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b, input logic [4:0] f);
    axil_master_i.write(off_op_a, a, rsp);
    axil_master_i.write(off_op_b, b, rsp);
    axil_master_i.write(off_flags, {27'h0, f}, rsp);
    axil_master_i.write(off_instr, ins, rsp);
    axil_master_i.write(off_ctrl, 32'h1, rsp);
    st = 32'h1;
    while (st[0] !== 1'b0) axil_master_i.read(off_ctrl, st, rsp);
    axil_master_i.read(off_result, res, rsp);
    axil_master_i.read(off_flags, fl, rsp);
    axil_master_i.read(off_status, st, rsp);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_bus;
    logic [31:0] d;
    axil_master_i.read(off_flags, d, rsp);
    check("flags reset", d, {27'h0, flags_reset});
    axil_master_i.read(off_instr, d, rsp);
    check("instr reset", d, instr_reset);
    axil_master_i.read(8'h40, d, rsp);
    check("unmapped data", d, 32'h0);
    check("unmapped resp", {30'h0, rsp}, {30'h0, resp_slverr});
    axil_master_i.write(off_op_a, 32'ha5c30f81, rsp);
    check("write resp", {30'h0, rsp}, {30'h0, resp_okay});
    axil_master_i.read(off_op_a, d, rsp);
    check("op_a readback", d, 32'ha5c30f81);
    check("read resp", {30'h0, rsp}, {30'h0, resp_okay});
    axil_master_i.write(8'h40, 32'h1, rsp);
    check("unmapped write resp", {30'h0, rsp}, {30'h0, resp_slverr});
  endtask
  task automatic t_sub;
    run(mk(4'h1, 4'h1, 4'h3, 4'h3, 5'h00, 1'b0, 1'b1), 32'h7fff8000, 32'hffff0001, 5'h1f);
    check("half result", res, 32'h7fff8000);
    check("half flags", fl, 32'h1f);
    run(mk(4'h2, 4'h1, 4'h3, 4'h3, 5'h00, 1'b0, 1'b1), 32'h7f800510, 32'hff010720, 5'h10);
    check("byte result", res, 32'h7f80fef0);
    check("byte flags", fl, 32'h10);
    axil_master_i.write(off_result, 32'h0, rsp);
    axil_master_i.read(off_result, res, rsp);
    check("read-only result", res, 32'h7f80fef0);
  endtask
  task automatic t_reverse;
    logic [31:0] ers [4] = '{32'h1f6a2c48, 32'hf8563412, 32'h3412f856, 32'hfffff856};
    for (int i = 0; i < 4; i++) begin
      run(mk(4'(3 + i), 4'h1, 4'h3, 4'h3, 5'h00, 1'b0, 1'b1), 32'h0, 32'h123456f8, 5'h00);
      check("reverse result", res, ers[i]);
    end
  endtask
  task automatic t_rotate;
    logic [31:0] src [4] = '{32'h81, 32'h1, 32'h0, 32'h81};
    logic [4:0]  amt [4] = '{5'h01, 5'h1f, 5'h04, 5'h01};
    logic [4:0]  fin [4] = '{5'h01, 5'h00, 5'h12, 5'h15};
    logic [4:0]  efl [4] = '{5'h0b, 5'h00, 5'h14, 5'h15};
    logic [31:0] ers [4] = '{32'h80000040, 32'h2, 32'h0, 32'h80000040};
    for (int i = 0; i < 4; i++) begin
      run(mk(4'h7, 4'h1, 4'h3, 4'h3, amt[i], i != 3, 1'b1), 32'h0, src[i], fin[i]);
      check("rotate result", res, ers[i]);
      check("rotate flags", fl, {27'h0, efl[i]});
      check("rotate status", st, 32'h1);
    end
  endtask
  task automatic t_refuse;
    logic [31:0] prev;
    logic [31:0] est [5] = '{32'h2, 32'h2, 32'h2, 32'h4, 32'h0};
    logic [31:0] ins [5] = '{mk(4'h5, 4'hd, 4'h3, 4'h3, 5'h00, 1'b0, 1'b1),
                             mk(4'h4, 4'h1, 4'hf, 4'hf, 5'h00, 1'b0, 1'b1),
                             mk(4'h3, 4'h1, 4'h2, 4'h4, 5'h00, 1'b0, 1'b1),
                             mk(4'h7, 4'h1, 4'h3, 4'h3, 5'h00, 1'b1, 1'b1),
                             mk(4'h7, 4'h1, 4'h3, 4'h3, 5'h01, 1'b1, 1'b0)};
    for (int i = 0; i < 5; i++) begin
      prev = res;
      run(ins[i], 32'h0, 32'h5a5a0001, 5'h0a);
      check("kept result", res, prev);
      check("kept flags", fl, 32'h0a);
      check("status", st, est[i]);
    end
  endtask
  initial begin
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_bus();
    t_sub();
    t_reverse();
    t_rotate();
    t_refuse();
    stop_test();
  end
endmodule
`default_nettype wire

// File: include/alu_if.sv
// Interface between the control module and the combinational execute unit.
`timescale 1ns/1ns
`default_nettype none
interface alu_if;
  import alu_pkg::*;
  alu_op_t     op;
  logic [31:0] op_a;
  logic [31:0] op_b;
  logic [4:0]  shift_amt;
  logic        carry_in;
  logic [31:0] result;
  logic        carry_out;
  modport ctrl (output op, op_a, op_b, shift_amt, carry_in, input result, carry_out);
  modport unit (input op, op_a, op_b, shift_amt, carry_in, output result, carry_out);
endinterface
`default_nettype wire

// File: include/alu_pkg.sv
// Package with opcodes, field positions, register numbers and bus offsets of the integer datapath.
package alu_pkg;

  typedef enum logic [3:0] {
    op_none          = 4'b0000,
    op_sat_sub_half  = 4'b0001,
    op_sat_sub_byte  = 4'b0010,
    op_bit_reverse   = 4'b0011,
    op_rev_word      = 4'b0100,
    op_rev_halves    = 4'b0101,
    op_rev_sign_half = 4'b0110,
    op_rotate_imm    = 4'b0111
  } alu_op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_exec = 2'b01,
    st_done = 2'b10
  } exec_state_t;

  localparam logic [3:0] reg_stack_num = 4'hd;
  localparam logic [3:0] reg_pc_num    = 4'hf;
  localparam logic [1:0] shift_type_ror = 2'b11;
  localparam logic [4:0] shift_amt_zero = 5'h00;

  localparam logic [7:0] off_ctrl    = 8'h00;
  localparam logic [7:0] off_instr   = 8'h04;
  localparam logic [7:0] off_op_a    = 8'h08;
  localparam logic [7:0] off_op_b    = 8'h0c;
  localparam logic [7:0] off_flags   = 8'h10;
  localparam logic [7:0] off_result  = 8'h14;
  localparam logic [7:0] off_status  = 8'h18;

  localparam int instr_op_lsb     = 0;
  localparam int instr_dest_lsb   = 4;
  localparam int instr_src_lsb    = 8;
  localparam int instr_src2_lsb   = 12;
  localparam int instr_first_lsb  = 16;
  localparam int instr_low_lsb    = 20;
  localparam int instr_high_lsb   = 22;
  localparam int instr_setf_bit   = 25;
  localparam int instr_cond_bit   = 26;
  localparam int instr_type_lsb   = 27;

  localparam int flag_v_bit = 0;
  localparam int flag_c_bit = 1;
  localparam int flag_z_bit = 2;
  localparam int flag_n_bit = 3;
  localparam int flag_q_bit = 4;

  localparam logic [31:0] instr_reset = 32'h00000000;
  localparam logic [4:0]  flags_reset = 5'h00;
  localparam logic [1:0]  resp_okay   = 2'b00;
  localparam logic [1:0]  resp_slverr = 2'b10;

endpackage

// File: verilog/alu_exec_unit.sv
// Combinational execute unit for saturating subtract, reversals and rotate.
`timescale 1ns/1ns
`default_nettype none
module alu_exec_unit
  import alu_pkg::*;
(
  alu_if.unit ex
);

  logic [31:0] sub_half;
  logic [31:0] sub_byte;
  logic [31:0] bit_rev;
  logic [63:0] rot_pair;
  logic [31:0] rot_res;

  genvar gi;
  generate
    // Each halfword lane subtracts and clamps to the signed 16-bit range.
    for (gi = 0; gi < 2; gi++) begin : g_half
      logic signed [16:0] d;
      assign d = 17'(signed'(ex.op_a[gi*16 +: 16])) - 17'(signed'(ex.op_b[gi*16 +: 16]));
      assign sub_half[gi*16 +: 16] = (d > 17'sd32767) ? 16'h7fff :
                                     (d < -17'sd32768) ? 16'h8000 : d[15:0];
    end
    // Each byte lane takes its operands from the same bit positions.
    for (gi = 0; gi < 4; gi++) begin : g_byte
      logic signed [8:0] d;
      assign d = 9'(signed'(ex.op_a[gi*8 +: 8])) - 9'(signed'(ex.op_b[gi*8 +: 8]));
      assign sub_byte[gi*8 +: 8] = (d > 9'sd127) ? 8'h7f :
                                   (d < -9'sd128) ? 8'h80 : d[7:0];
    end
    for (gi = 0; gi < 32; gi++) begin : g_rev
      assign bit_rev[31 - gi] = ex.op_b[gi];
    end
  endgenerate

  // Rotation: bits leaving bit 0 return at bit 31.
  assign rot_pair = {ex.op_b, ex.op_b} >> ex.shift_amt;
  assign rot_res  = rot_pair[31:0];

  always_comb begin
    ex.carry_out = ex.carry_in;
    case (ex.op)
      op_sat_sub_half:  ex.result = sub_half;
      op_sat_sub_byte:  ex.result = sub_byte;
      op_bit_reverse:   ex.result = bit_rev;
      op_rev_word:      ex.result = {ex.op_b[7:0], ex.op_b[15:8], ex.op_b[23:16], ex.op_b[31:24]};
      op_rev_halves:    ex.result = {ex.op_b[23:16], ex.op_b[31:24], ex.op_b[7:0], ex.op_b[15:8]};
      op_rev_sign_half: ex.result = {{16{ex.op_b[7]}}, ex.op_b[7:0], ex.op_b[15:8]};
      op_rotate_imm: begin
        ex.result    = rot_res;
        ex.carry_out = rot_res[31];
      end
      default:          ex.result = 32'h00000000;
    endcase
  end

endmodule
`default_nettype wire

// File: verilog/sat_sub_reverse_rotate_alu.sv
// Integer datapath with decode checks, flag state and an AXI4-Lite register slave.
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
//
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module sat_sub_reverse_rotate_alu
  import alu_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axil_awaddr,
  input  wire logic        s_axil_awvalid,
  output var  logic        s_axil_awready,
  input  wire logic [31:0] s_axil_wdata,
  input  wire logic [3:0]  s_axil_wstrb,
  input  wire logic        s_axil_wvalid,
  output var  logic        s_axil_wready,
  output var  logic [1:0]  s_axil_bresp,
  output var  logic        s_axil_bvalid,
  input  wire logic        s_axil_bready,
  input  wire logic [7:0]  s_axil_araddr,
  input  wire logic        s_axil_arvalid,
  output var  logic        s_axil_arready,
  output var  logic [31:0] s_axil_rdata,
  output var  logic [1:0]  s_axil_rresp,
  output var  logic        s_axil_rvalid,
  input  wire logic        s_axil_rready
);

  alu_if ex_bus ();

  logic [31:0] instr_reg;
  logic [31:0] op_a_reg;
  logic [31:0] op_b_reg;
  logic [4:0]  flags_reg;
  logic [31:0] result_reg;
  logic        result_written_reg;
  logic        unpred_reg;
  logic        rot_ext_reg;
  logic        busy_reg;
  exec_state_t state_reg;
  logic [7:0]  aw_addr_reg;
  logic        aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_have_reg;
  logic        start_pulse;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction decode.
  alu_op_t     dec_op;
  logic [3:0]  dest_reg_field;
  logic [3:0]  source_reg_field;
  logic [3:0]  source_copy_field;
  logic [3:0]  first_operand_field;
  logic [2:0]  shift_high_field;
  logic [1:0]  shift_low_field;
  logic [4:0]  shift_amount;
  logic        shift_is_rotate;
  logic        set_flags;
  logic        cond_pass;
  logic        uses_first;
  logic        is_reversal;
  logic        is_rotate_extend;
  logic        bad_regs;
  logic        bad_copy;
  logic        unpredictable;
  logic        exec_ok;
  logic [31:0] status_word;

  assign dec_op              = alu_op_t'(instr_reg[instr_op_lsb +: 4]);
  assign dest_reg_field      = instr_reg[instr_dest_lsb +: 4];
  assign source_reg_field    = instr_reg[instr_src_lsb +: 4];
  assign source_copy_field   = instr_reg[instr_src2_lsb +: 4];
  assign first_operand_field = instr_reg[instr_first_lsb +: 4];
  assign shift_low_field     = instr_reg[instr_low_lsb +: 2];
  assign shift_high_field    = instr_reg[instr_high_lsb +: 3];
  assign set_flags           = instr_reg[instr_setf_bit];
  assign cond_pass           = instr_reg[instr_cond_bit];

  // The rotate amount is the five-bit immediate under the rotate shift type.
  assign shift_is_rotate = (instr_reg[instr_type_lsb +: 2] == shift_type_ror);
  assign shift_amount    = shift_is_rotate ? {shift_high_field, shift_low_field} : shift_amt_zero;
  assign is_rotate_extend = (dec_op == op_rotate_imm) && (shift_amount == shift_amt_zero);

  assign uses_first  = (dec_op == op_sat_sub_half) || (dec_op == op_sat_sub_byte);
  assign is_reversal = (dec_op == op_bit_reverse) || (dec_op == op_rev_word) ||
                       (dec_op == op_rev_halves) || (dec_op == op_rev_sign_half);

  assign bad_regs = (dest_reg_field == reg_stack_num) || (dest_reg_field == reg_pc_num) ||
                    (source_reg_field == reg_stack_num) || (source_reg_field == reg_pc_num) ||
                    (uses_first && ((first_operand_field == reg_stack_num) ||
                                    (first_operand_field == reg_pc_num)));
  assign bad_copy = is_reversal && (source_copy_field != source_reg_field);
  assign unpredictable = (dec_op != op_none) && (bad_regs || bad_copy);

  // An instruction takes effect only when its condition passes and its encoding is usable.
  assign exec_ok = cond_pass && !unpredictable && !is_rotate_extend && (dec_op != op_none);

  assign ex_bus.op        = dec_op;
  assign ex_bus.op_a      = op_a_reg;
  assign ex_bus.op_b      = op_b_reg;
  assign ex_bus.shift_amt = shift_amount;
  assign ex_bus.carry_in  = flags_reg[flag_c_bit];

  alu_exec_unit u_exec (
    .ex (ex_bus.unit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Execution sequencing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_idle: if (start_pulse) state_reg <= st_exec;
        st_exec: state_reg <= st_done;
        st_done: state_reg <= st_idle;
        default: state_reg <= st_idle;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_reg == st_idle) ? start_pulse : (state_reg == st_exec);
    end
  end

  // Result is written only when the condition passes and the encoding is usable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg         <= 32'h00000000;
      result_written_reg <= 1'b0;
    end else if (state_reg == st_exec) begin
      if (exec_ok) begin
        result_reg         <= ex_bus.result;
        result_written_reg <= 1'b1;
      end else begin
        result_written_reg <= 1'b0;
      end
    end
  end

  // Status bits describe how the last started instruction was treated.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unpred_reg  <= 1'b0;
      rot_ext_reg <= 1'b0;
    end else if (state_reg == st_exec) begin
      unpred_reg  <= unpredictable;
      rot_ext_reg <= is_rotate_extend;
    end
  end

  // Flags change only for a passing rotate with its set bit high.
  // A software write wins over an update in the same cycle, so the written value is never lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= flags_reset;
    end else if (aw_have_reg && w_have_reg && !s_axil_bvalid && (aw_addr_reg == off_flags) && w_strb_reg[0]) begin
      flags_reg <= w_data_reg[4:0];
    end else if ((state_reg == st_exec) && exec_ok && (dec_op == op_rotate_imm) &&
                 set_flags) begin
      flags_reg[flag_n_bit] <= ex_bus.result[31];
      flags_reg[flag_z_bit] <= (ex_bus.result == 32'h00000000);
      flags_reg[flag_c_bit] <= ex_bus.carry_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel.
  logic wr_fire;
  assign wr_fire = aw_have_reg && w_have_reg && !s_axil_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg    <= 1'b0;
      aw_addr_reg    <= 8'h00;
      s_axil_awready <= 1'b0;
    end else begin
      s_axil_awready <= !aw_have_reg && !s_axil_awready && s_axil_awvalid;
      if (s_axil_awvalid && s_axil_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axil_awaddr;
      end else if (wr_fire) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg    <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      s_axil_wready <= 1'b0;
    end else begin
      s_axil_wready <= !w_have_reg && !s_axil_wready && s_axil_wvalid;
      if (s_axil_wvalid && s_axil_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axil_wdata;
        w_strb_reg <= s_axil_wstrb;
      end else if (wr_fire) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= resp_okay;
    end else if (wr_fire) begin
      s_axil_bvalid <= 1'b1;
      case (aw_addr_reg)
        off_ctrl, off_instr, off_op_a, off_op_b, off_flags: s_axil_bresp <= resp_okay;
        default: s_axil_bresp <= resp_slverr;
      endcase
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  // Writing bit 0 of the control word while idle starts one instruction.
  assign start_pulse = wr_fire && (aw_addr_reg == off_ctrl) && w_strb_reg[0] && w_data_reg[0] &&
                       (state_reg == st_idle);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_reg <= instr_reset;
      op_a_reg  <= 32'h00000000;
      op_b_reg  <= 32'h00000000;
    end else if (wr_fire && (state_reg == st_idle)) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb_reg[i]) begin
          if (aw_addr_reg == off_instr) instr_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
          if (aw_addr_reg == off_op_a)  op_a_reg[i*8 +: 8]  <= w_data_reg[i*8 +: 8];
          if (aw_addr_reg == off_op_b)  op_b_reg[i*8 +: 8]  <= w_data_reg[i*8 +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.
  assign status_word = {29'h00000000, rot_ext_reg, unpred_reg, result_written_reg};

  // A new read address is refused while the previous answer waits, so answers never overlap.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid  <= 1'b0;
      s_axil_rdata   <= 32'h00000000;
      s_axil_rresp   <= resp_okay;
    end else begin
      s_axil_arready <= !s_axil_rvalid && !s_axil_arready && s_axil_arvalid;
      if (s_axil_arvalid && s_axil_arready) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rresp  <= resp_okay;
        case (s_axil_araddr)
          off_ctrl:   s_axil_rdata <= {31'h00000000, busy_reg};
          off_instr:  s_axil_rdata <= instr_reg;
          off_op_a:   s_axil_rdata <= op_a_reg;
          off_op_b:   s_axil_rdata <= op_b_reg;
          off_flags:  s_axil_rdata <= {27'h0000000, flags_reg};
          off_result: s_axil_rdata <= result_reg;
          off_status: s_axil_rdata <= status_word;
          default: begin
            s_axil_rdata <= 32'h00000000;
            s_axil_rresp <= resp_slverr;
          end
        endcase
      end else if (s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire
